/* File: hw/tlp_tx_defines.svh */
`ifndef TLP_TX_DEFINES_SVH
`define TLP_TX_DEFINES_SVH

// Sideband bit positions on the transmit user field
`define TXU_DIGEST 0
`define TXU_POISON 1
`define TXU_CUT 2
`define TXU_ABORT 3

// Header bit positions in the first word (first dword on bits 31..0)
`define HDR_FMT_DATA 30
`define HDR_TD 15
`define HDR_EP 14
`define HDR_LEN_MSB 9

// Byte-keep codes for a final beat
`define KEEP_FULL 8'hff
`define KEEP_LOW 8'h0f

// Digest arithmetic
`define CRC_INIT 32'hffffffff
`define CRC_POLY 32'h04c11db7

// Payload limits: smallest size code means this many bytes
`define MPS_BASE_BYTES 13'h0080
`define LEN_ZERO_BYTES 13'h1000

// Power state field value for full power
`define PWR_D0 2'h0

// Latest edge after the final beat for the drop flag
`define DROP_LAT_CYCLES 2

`endif

/* File: hw/tlp_tx_pkg.sv */
package tlp_tx_pkg;

  // Transmit port sequencing states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PKT = 2'b01,
    ST_DIGEST = 2'b10,
    ST_INTERNAL = 2'b11
  } tx_state_t;

endpackage

/* File: hw/crc_word_step.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tlp_tx_defines.svh"

// One word of digest arithmetic, bytes taken in wire order:
// low dword first, most significant byte of each dword first.
module crc_word_step #(
  parameter int BYTES = 8
) (
  // Running value in
  input wire logic [31:0] crc_in,
  // Word and its byte-keep
  input wire logic [BYTES*8-1:0] data,
  input wire logic [BYTES-1:0] keep,
  // Running value out
  output logic [31:0] crc_out
);

  // Byte-serial unrolled update, skipping bytes not kept
  always_comb begin
    logic [31:0] c;
    logic [7:0] b;
    int dw;
    int bi;
    int idx;
    dw = 0;
    bi = 0;
    idx = 0;
    c = crc_in;
    b = 8'h00;
    for (dw = 0; dw < BYTES / 4; dw++) begin
      for (bi = 3; bi >= 0; bi--) begin
        idx = dw * 4 + bi;
        b = data[idx*8 +: 8];
        if (keep[idx]) begin
          for (int k = 7; k >= 0; k--) begin
            c = (c[31] ^ b[k]) ? ((c << 1) ^ `CRC_POLY) : (c << 1);
          end
        end
      end
    end
    crc_out = c;
  end

endmodule
`default_nettype wire

/* File: hw/tlp_transmit_stream_port.sv */
// Functional notes
// - Data ignored whenever valid is low
// - Buffer-full throttle only at packet boundary
// - Started packet is always accepted completely
// - Ready low at packet boundary when link credits are exhausted
// - Ready low while sending granted internal packet
// - Non-D0 power: finish packet, then hold ready low
// - Abort counts only with valid and ready
// - Abort ignored on first beat, or idle
// - Abort: discard, or end with EDB if cut-through
// - Drop on link down, oversize, cut-through gap: discard, or EDB if cut-through
// - Accept rest; drop flag within two cycles
// - Poison sideband sets header poison bit
// - Throttled cut-through: drop, flag, nullified packet
// - Digest requested at first beat, TD set
// - Ready low exactly one cycle for digest
// - Final keep is all ones or low four bytes
`timescale 1ns/10ps
`default_nettype none
`include "tlp_tx_defines.svh"

module tlp_transmit_stream_port #(
  parameter int DATA_W = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Transmit stream from the application
  input wire logic [DATA_W-1:0] s_axis_tx_tdata,
  input wire logic [DATA_W/8-1:0] s_axis_tx_tkeep,
  input wire logic s_axis_tx_tlast,
  input wire logic s_axis_tx_tvalid,
  input wire logic [3:0] s_axis_tx_tuser,
  output logic s_axis_tx_tready,
  output logic tx_err_drop,
  // Internal packet arbitration
  input wire logic int_pkt_pending,
  input wire logic int_pkt_done,
  input wire logic tx_cfg_gnt,
  output logic tx_cfg_req,
  output logic int_pkt_send,
  // Device state
  input wire logic pool_room,
  input wire logic credits_ok,
  input wire logic link_up,
  input wire logic [1:0] power_state,
  input wire logic [2:0] max_payload_cap,
  // Words toward the buffer pool and link
  output logic [DATA_W-1:0] out_data,
  output logic [DATA_W/8-1:0] out_keep,
  output logic out_valid,
  output logic out_last,
  output logic out_discard,
  output logic out_edb,
  output logic out_set_ep
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  tlp_tx_pkg::tx_state_t state_q, state_d;
  logic ready_q, ready_d;
  // Per-packet flags, merged up to the last accepted beat
  logic cut_q, cut_d;
  logic dig_q, dig_d;
  logic poison_q, poison_d;
  logic abort_q, abort_d;
  logic drop_q, drop_d;
  logic [31:0] crc_q, crc_d;
  logic [31:0] crc_next;
  logic err_drop_q, err_drop_d;
  logic req_q;
  logic send_q, send_d;
  // Output word registers
  logic [DATA_W-1:0] odata_q, odata_d;
  logic [DATA_W/8-1:0] okeep_q, okeep_d;
  logic ovalid_q, ovalid_d;
  logic olast_q, olast_d;
  logic odisc_q, odisc_d;
  logic oedb_q, oedb_d;
  logic oep_q, oep_d;
  // Helpers
  logic accept;
  logic boundary_ok;
  logic [12:0] len_bytes;
  logic [12:0] mps_bytes;
  logic oversize;
  logic [DATA_W-1:0] word_patched;

  // Valid-and-ready handshake; data is otherwise ignored
  assign accept = s_axis_tx_tvalid & ready_q;

  // Conditions that may open the port for a new packet
  assign boundary_ok = pool_room & credits_ok & (power_state == `PWR_D0) &
                       ~(int_pkt_pending & tx_cfg_gnt);

  // Payload size from the header length field; zero means the maximum
  assign len_bytes = (s_axis_tx_tdata[`HDR_LEN_MSB:0] == 10'h000) ? `LEN_ZERO_BYTES :
                     {1'b0, s_axis_tx_tdata[`HDR_LEN_MSB:0], 2'b00};
  assign mps_bytes = `MPS_BASE_BYTES << max_payload_cap;
  assign oversize = s_axis_tx_tdata[`HDR_FMT_DATA] & (len_bytes > mps_bytes);

  // TD is written in the first word when a digest will be appended
  always_comb begin
    word_patched = s_axis_tx_tdata;
    if (state_q == tlp_tx_pkg::ST_IDLE && s_axis_tx_tuser[`TXU_DIGEST] &&
        !s_axis_tx_tdata[`HDR_TD]) begin
      word_patched[`HDR_TD] = 1'b1;
    end
  end

  // Running digest over accepted words
  crc_word_step #(
    .BYTES(DATA_W/8)
  ) u_crc (
    .crc_in((state_q == tlp_tx_pkg::ST_IDLE) ? `CRC_INIT : crc_q),
    .data(word_patched),
    .keep(s_axis_tx_tkeep),
    .crc_out(crc_next)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencing and packet flags

  // Next state, ready and flag merging
  always_comb begin
    logic f_cut;
    logic f_dig;
    logic f_poison;
    logic f_abort;
    logic f_drop;
    logic first;
    first = (state_q == tlp_tx_pkg::ST_IDLE);
    state_d = state_q;
    ready_d = ready_q;
    send_d = send_q;
    crc_d = crc_q;
    err_drop_d = 1'b0;
    // Merge current beat into the packet flags
    f_cut = first ? s_axis_tx_tuser[`TXU_CUT] : cut_q;
    f_dig = first ? (s_axis_tx_tuser[`TXU_DIGEST] & ~s_axis_tx_tdata[`HDR_TD]) : dig_q;
    f_poison = (first ? 1'b0 : poison_q) | s_axis_tx_tuser[`TXU_POISON];
    // Abort on a first beat does nothing
    f_abort = ~first & (abort_q | s_axis_tx_tuser[`TXU_ABORT]);
    f_drop = first ? (oversize | ~link_up) : (drop_q | ~link_up);
    cut_d = cut_q;
    dig_d = dig_q;
    poison_d = poison_q;
    abort_d = abort_q;
    drop_d = drop_q;
    if (accept) begin
      cut_d = f_cut;
      dig_d = f_dig;
      poison_d = f_poison;
      abort_d = f_abort;
      drop_d = f_drop;
      crc_d = crc_next;
    end
    case (state_q)
      tlp_tx_pkg::ST_IDLE: begin
        if (accept && !s_axis_tx_tlast) begin
          state_d = tlp_tx_pkg::ST_PKT;
          ready_d = 1'b1;
        end else if (accept && f_dig) begin
          state_d = tlp_tx_pkg::ST_DIGEST;
          ready_d = 1'b0;
        end else if (accept) begin
          err_drop_d = f_drop;
          ready_d = boundary_ok;
        end else if (int_pkt_pending && tx_cfg_gnt) begin
          state_d = tlp_tx_pkg::ST_INTERNAL;
          ready_d = 1'b0;
          send_d = 1'b1;
        end else begin
          ready_d = boundary_ok;
        end
      end
      tlp_tx_pkg::ST_PKT: begin
        // A gap in a cut-through packet kills it
        if (!s_axis_tx_tvalid && cut_q) begin
          drop_d = 1'b1;
        end
        if (accept && s_axis_tx_tlast) begin
          if (f_dig) begin
            state_d = tlp_tx_pkg::ST_DIGEST;
            ready_d = 1'b0;
          end else begin
            state_d = tlp_tx_pkg::ST_IDLE;
            err_drop_d = f_drop;
            ready_d = boundary_ok;
          end
        end else begin
          ready_d = 1'b1;
        end
      end
      tlp_tx_pkg::ST_DIGEST: begin
        // Digest slot takes exactly one cycle
        state_d = tlp_tx_pkg::ST_IDLE;
        err_drop_d = drop_q;
        ready_d = boundary_ok;
      end
      tlp_tx_pkg::ST_INTERNAL: begin
        // Ready returns once the internal packet has gone
        if (int_pkt_done) begin
          state_d = tlp_tx_pkg::ST_IDLE;
          send_d = 1'b0;
          ready_d = boundary_ok;
        end else begin
          ready_d = 1'b0;
        end
      end
      default: begin
        state_d = tlp_tx_pkg::ST_IDLE;
        ready_d = 1'b0;
        send_d = 1'b0;
      end
    endcase
  end

  // Sequencing registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= tlp_tx_pkg::ST_IDLE;
      ready_q <= 1'b0;
      send_q <= 1'b0;
      req_q <= 1'b0;
      cut_q <= 1'b0;
      dig_q <= 1'b0;
      poison_q <= 1'b0;
      abort_q <= 1'b0;
      drop_q <= 1'b0;
      crc_q <= `CRC_INIT;
      err_drop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      send_q <= send_d;
      req_q <= int_pkt_pending;
      cut_q <= cut_d;
      dig_q <= dig_d;
      poison_q <= poison_d;
      abort_q <= abort_d;
      drop_q <= drop_d;
      crc_q <= crc_d;
      err_drop_q <= err_drop_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output words

  // Forward accepted beats, or the digest word in its slot
  always_comb begin
    logic fin;
    logic bad;
    odata_d = odata_q;
    okeep_d = okeep_q;
    ovalid_d = 1'b0;
    olast_d = 1'b0;
    odisc_d = 1'b0;
    oedb_d = 1'b0;
    oep_d = 1'b0;
    fin = 1'b0;
    bad = abort_d | drop_d;
    if (accept) begin
      ovalid_d = 1'b1;
      odata_d = word_patched;
      okeep_d = s_axis_tx_tkeep;
      fin = s_axis_tx_tlast & ~dig_d;
    end else if (state_q == tlp_tx_pkg::ST_DIGEST) begin
      ovalid_d = 1'b1;
      odata_d = {{(DATA_W-32){1'b0}}, ~crc_q};
      okeep_d = `KEEP_LOW;
      fin = 1'b1;
    end
    if (fin) begin
      olast_d = 1'b1;
      odisc_d = bad & ~cut_d;
      oedb_d = bad & cut_d;
      oep_d = poison_d;
    end
  end

  // Output registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      odata_q <= '0;
      okeep_q <= '0;
      ovalid_q <= 1'b0;
      olast_q <= 1'b0;
      odisc_q <= 1'b0;
      oedb_q <= 1'b0;
      oep_q <= 1'b0;
    end else begin
      odata_q <= odata_d;
      okeep_q <= okeep_d;
      ovalid_q <= ovalid_d;
      olast_q <= olast_d;
      odisc_q <= odisc_d;
      oedb_q <= oedb_d;
      oep_q <= oep_d;
    end
  end

  assign s_axis_tx_tready = ready_q;
  assign tx_err_drop = err_drop_q;
  assign tx_cfg_req = req_q;
  assign int_pkt_send = send_q;
  assign out_data = odata_q;
  assign out_keep = okeep_q;
  assign out_valid = ovalid_q;
  assign out_last = olast_q;
  assign out_discard = odisc_q;
  assign out_edb = oedb_q;
  assign out_set_ep = oep_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_midpkt_ready: assert property ((state_q == tlp_tx_pkg::ST_PKT) |-> ready_q)
    else $error("ready dropped inside a packet");
  a_digest_gap: assert property (accept && s_axis_tx_tlast && dig_d |=> !ready_q ##1 (ready_q == $past(boundary_ok)))
    else $error("digest slot not one cycle");
  a_drop_pulse: assert property (tx_err_drop |=> !tx_err_drop || $past(accept && s_axis_tx_tlast))
    else $error("drop flag longer than one cycle");
  a_drop_timing: assert property (accept && s_axis_tx_tlast && drop_d && !dig_d |=> tx_err_drop)
    else $error("drop flag late");
  a_power_hold: assert property ((state_q == tlp_tx_pkg::ST_IDLE) && (power_state != `PWR_D0) |=> !ready_q)
    else $error("ready high in low power");
  a_internal_hold: assert property ((state_q == tlp_tx_pkg::ST_INTERNAL) |-> !ready_q && int_pkt_send)
    else $error("ready high during internal packet");
  a_first_abort: assert property (accept && (state_q == tlp_tx_pkg::ST_IDLE) && s_axis_tx_tuser[`TXU_ABORT] |=> !abort_q)
    else $error("abort honoured on first beat");
  a_poison_ep: assert property (accept && s_axis_tx_tlast && !dig_d && poison_d |=> out_set_ep && out_last)
    else $error("poison not forwarded");
  a_cut_edb: assert property (accept && s_axis_tx_tlast && !dig_d && cut_d && drop_d |=> out_edb && !out_discard)
    else $error("throttled cut-through not nullified");
  a_no_idle_out: assert property (!accept && state_q != tlp_tx_pkg::ST_DIGEST |=> !out_valid)
    else $error("word forwarded without handshake");

  c_back_to_back: cover property (accept && s_axis_tx_tlast ##1 accept);
  c_digest: cover property (state_q == tlp_tx_pkg::ST_DIGEST);
  c_cut_drop: cover property (out_edb && tx_err_drop);
  c_internal: cover property (state_q == tlp_tx_pkg::ST_INTERNAL ##1 state_q == tlp_tx_pkg::ST_IDLE);

endmodule
`default_nettype wire

/* File: tb/tlp_app_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Application side: offers packet words and grants internal packets
module tlp_app_model (
  // Clock and answers
  input wire logic clk,
  input wire logic tready,
  input wire logic cfg_req,
  // Stream toward the port
  output logic [63:0] tdata,
  output logic [7:0] tkeep,
  output logic tlast,
  output logic tvalid,
  output logic [3:0] tuser,
  output logic cfg_gnt
);
  ////////////////////////////////////////////////////////////
  // Known values from time zero
  initial begin
    tdata = 64'h0;
    tkeep = 8'h00;
    tlast = 1'b0;
    tvalid = 1'b0;
    tuser = 4'h0;
    cfg_gnt = 1'b0;
  end
  // Grant only between own words, so a request never waits long
  always @(posedge clk) begin
    cfg_gnt <= cfg_req && !tvalid;
  end
  // Offer one word, hold it until taken; valid stays up for the next one
  task automatic beat(input logic [63:0] d, input logic [7:0] k, input logic l, input logic [3:0] u,
                      output logic ok);
    int n;
    n = 0;
    tdata <= d;
    tkeep <= k;
    tlast <= l;
    tuser <= u;
    tvalid <= 1'b1;
    @(posedge clk);
    while (!tready && n < 200) begin
      n++;
      @(posedge clk);
    end
    ok = (n < 200);
  endtask
  // Idle cycles; stale data is inverted so a wrong capture shows
  task automatic idle(input int c);
    tvalid <= 1'b0;
    tlast <= 1'b0;
    tdata <= ~tdata;
    repeat (c) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/tlp_transmit_stream_port_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module tlp_transmit_stream_port_bench;
  // Clock, reset and device state
  logic clk = 1'b0, resetn = 1'b0, pend = 1'b0, done = 1'b0, pool = 1'b1, cred = 1'b1, link = 1'b1;
  logic [1:0] pwr = 2'h0;
  logic [2:0] cap = 3'h5;
  // Stream and outputs
  logic [63:0] tdata, od;
  logic [7:0] tkeep, ok_;
  logic [3:0] tuser;
  logic tlast, tvalid, tready, drop, gnt, req, send, ov, ol, odis, oedb, oep;
  // Scoreboard: {dont care, last, keep, data}
  logic [73:0] exq[$];
  logic [73:0] e;
  logic in_pkt = 1'b0, dig = 1'b0;
  logic [2:0] fl = 3'h0;
  // Word as it should leave, and the running digest of the packet
  logic [63:0] pw;
  logic [31:0] ecrc = 32'hffffffff;
  int drops = 0, n_mismatch = 0, cmp_count = 0, r;
  localparam logic [2:0] ft [7] = '{3'b100, 3'b100, 3'b010, 3'b100, 3'b010, 3'b000, 3'b000};
  always #10 clk = ~clk;
  tlp_app_model app (.clk(clk), .tready(tready), .cfg_req(req), .tdata(tdata), .tkeep(tkeep),
    .tlast(tlast), .tvalid(tvalid), .tuser(tuser), .cfg_gnt(gnt));
  tlp_transmit_stream_port dut (.clk(clk), .resetn(resetn), .s_axis_tx_tdata(tdata),
    .s_axis_tx_tkeep(tkeep), .s_axis_tx_tlast(tlast), .s_axis_tx_tvalid(tvalid),
    .s_axis_tx_tuser(tuser), .s_axis_tx_tready(tready), .tx_err_drop(drop), .int_pkt_pending(pend),
    .int_pkt_done(done), .tx_cfg_gnt(gnt), .tx_cfg_req(req), .int_pkt_send(send), .pool_room(pool),
    .credits_ok(cred), .link_up(link), .power_state(pwr), .max_payload_cap(cap), .out_data(od),
    .out_keep(ok_), .out_valid(ov), .out_last(ol), .out_discard(odis), .out_edb(oedb), .out_set_ep(oep));
  ////////////////////////////////////////////////////////////
  // Accepted words predict the output; TD patched and digest word added
  always @(posedge clk) begin
    if (tvalid && tready) begin
      if (!in_pkt) begin
        dig = tuser[0] && !tdata[15];
        ecrc = 32'hffffffff;
      end
      pw = tdata | ((!in_pkt && dig) ? 64'h8000 : 64'h0);
      ecrc = crc_step(ecrc, pw, tkeep);
      exq.push_back({1'b0, tlast && !dig, tkeep, pw});
      if (tlast && dig) exq.push_back({2'b01, 8'h0f, 32'h0, ~ecrc});
      in_pkt = !tlast;
    end
    if (ov) begin
      e = exq.pop_front();
      check({ol, ok_, e[73] ? 64'h0 : od}, e[72:0]);
    end
    if (ov && ol) fl = {odis, oedb, oep};
    if (drop) drops++;
  end
  // Digest over one word: low dword first, high byte of each dword first
  function automatic logic [31:0] crc_step(input logic [31:0] c0, input logic [63:0] d, input logic [7:0] k);
    logic [31:0] c;
    int j;
    c = c0;
    for (int i = 0; i < 8; i++) begin
      j = (i < 4) ? 3 - i : 11 - i;
      if (k[j]) begin
        for (int b = 7; b >= 0; b--) begin
          c = (c[31] ^ d[j * 8 + b]) ? ((c << 1) ^ 32'h04c11db7) : (c << 1);
        end
      end
    end
    return c;
  endfunction
  // One comparison
  task automatic check(input logic [72:0] got, input logic [72:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic finish_test;
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One packet; pb poison beat, ab abort beat, gb gap after beat
  task automatic pkt(input int n, input logic [63:0] fw, input logic [3:0] u, input int pb, input int ab,
                     input int gb, input logic [7:0] lk);
    logic ok;
    logic [63:0] d;
    for (int i = 0; i < n; i++) begin
      d = (i == 0) ? fw : {$urandom, $urandom};
      if (i == n - 1 && lk == 8'h0f) d[63:32] = 32'h0;
      app.beat(d, (i == n - 1) ? lk : 8'hff, i == n - 1, u | {ab == i, 1'b0, pb == i, 1'b0}, ok);
      if (!ok) begin
        n_mismatch++;
        finish_test();
      end
      // Gaps only inside a packet; a gap after the last beat would hide the digest slot
      if (i == gb && i < n - 1) app.idle(1);
    end
  endtask
  // Let the packet drain, then check drop count and end flags
  task automatic settle(input int d0, input int ed, input logic [2:0] ef);
    app.idle(4);
    check(73'(drops - d0), 73'(ed));
    check(73'(fl), 73'(ef));
  endtask
  // Bounded wait for the internal-packet level
  task automatic wait_send(input logic v);
    int w;
    w = 0;
    while (send !== v && w < 50) begin
      w++;
      @(posedge clk);
    end
    if (send !== v) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    int n, pb, gb, d0;
    logic dg, o1, o2, o3;
    r = $urandom(56);
    repeat (20) @(posedge clk);
    check(73'(tready), 73'h0);
    resetn <= 1'b1;
    // Idle throttles: pool full, no credits, one random low-power state
    for (int k = 0; k < 3; k++) begin
      pool <= (k != 0);
      cred <= (k != 1);
      pwr <= (k == 2) ? 2'(1 + $urandom % 3) : 2'h0;
      app.idle(3);
      check(73'(tready), 73'h0);
      pool <= 1'b1;
      cred <= 1'b1;
      pwr <= 2'h0;
      app.idle(3);
      check(73'(tready), 73'h1);
    end
    // Random traffic, often back to back, with gaps, poison and digests
    for (int p = 0; p < 40; p++) begin
      n = 1 + $urandom % 4;
      dg = 1'($urandom % 2);
      // No poison sideband when a digest is asked for
      pb = dg ? -1 : int'($urandom % 5) - 1;
      gb = int'($urandom % 6) - 1;
      d0 = drops;
      // Headers carry no payload flag, so any legal capability code is in range
      cap <= 3'($urandom % 6);
      // Header poison bit is left random: the source may set it itself
      pkt(n, {$urandom, $urandom} & ~64'h4000_8000, {3'b000, dg}, pb, -1, gb,
          ($urandom % 2) ? 8'hff : 8'h0f);
      if (dg) begin
        app.idle(1);
        check(73'(tready), 73'h0);
        app.idle(1);
        check(73'(tready), 73'h1);
      end
      if (dg || $urandom % 2) settle(d0, 0, {2'b00, pb >= 0 && pb < n});
    end
    // Discard reasons, aborts and the size boundary; no poison on cut-through
    cap <= 3'h0;
    for (int c = 0; c < 7; c++) begin
      d0 = drops;
      link <= (c != 1);
      pkt(3, (c == 0) ? 64'h4000_0040 : (c == 6) ? 64'h4000_0020 : 64'h0, {1'b0, c == 2 || c == 4, 2'b00},
          -1, (c == 3 || c == 4) ? 1 : (c == 5) ? 0 : -1, (c == 2) ? 0 : -1, 8'hff);
      link <= 1'b1;
      settle(d0, c < 3, ft[c]);
    end
    cap <= 3'h5;
    // Power leaves D0 mid-packet: packet still finishes, then ready stays low
    app.beat(64'h1, 8'hff, 1'b0, 4'h0, o1);
    pwr <= 2'h1;
    pool <= 1'b0;
    app.beat(64'h2, 8'hff, 1'b0, 4'h0, o2);
    app.beat(64'h3, 8'hff, 1'b1, 4'h0, o3);
    check(73'({o1, o2, o3}), 73'h7);
    app.idle(3);
    check(73'(tready), 73'h0);
    pwr <= 2'h0;
    pool <= 1'b1;
    // Internal packet takes the datapath once granted
    pend <= 1'b1;
    wait_send(1'b1);
    repeat (4) @(posedge clk);
    check(73'({req, send, tready}), 73'h6);
    done <= 1'b1;
    pend <= 1'b0;
    @(posedge clk);
    done <= 1'b0;
    wait_send(1'b0);
    @(posedge clk);
    check(73'(tready), 73'h1);
    finish_test();
  end
endmodule
`default_nettype wire
